//--- sdetv_cfg.svh
`ifndef SDETV_CFG_SVH
`define SDETV_CFG_SVH

// ----------------------------------------------------------------
// Register subaddresses
// ----------------------------------------------------------------
`define SDETV_ADDR_TIMING1      8'h8b
`define SDETV_ADDR_FSC0         8'h8c
`define SDETV_ADDR_FSC1         8'h8d
`define SDETV_ADDR_FSC2         8'h8e
`define SDETV_ADDR_FSC3         8'h8f
`define SDETV_ADDR_PHASE        8'h90
`define SDETV_ADDR_CAP_EVEN_LO  8'h91
`define SDETV_ADDR_CAP_EVEN_HI  8'h92
`define SDETV_ADDR_CAP_ODD_LO   8'h93
`define SDETV_ADDR_CAP_ODD_HI   8'h94
`define SDETV_ADDR_PED_ODD_A    8'h95
`define SDETV_ADDR_PED_ODD_B    8'h96
`define SDETV_ADDR_PED_EVEN_A   8'h97
`define SDETV_ADDR_PED_EVEN_B   8'h98
`define SDETV_ADDR_COPY_CTRL    8'h99
`define SDETV_ADDR_COPY_MID     8'h9a
`define SDETV_ADDR_COPY_LOW     8'h9b
`define SDETV_ADDR_SCALE_LSB    8'h9c
`define SDETV_ADDR_Y_SCALE      8'h9d
`define SDETV_ADDR_CB_SCALE     8'h9e
`define SDETV_ADDR_CR_SCALE     8'h9f
`define SDETV_ADDR_HUE          8'ha0
`define SDETV_ADDR_BRIGHT       8'ha1
`define SDETV_ADDR_SHAPING      8'ha2
`define SDETV_NUM_REGS          24

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDETV_RST_FSC0          8'h1f
`define SDETV_RST_FSC1          8'h7c
`define SDETV_RST_FSC2          8'hf0
`define SDETV_RST_FSC3          8'h21
`define SDETV_RST_OTHER         8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDETV_HS_WIDTH_LSB      0
`define SDETV_HV_DELAY_LSB      2
`define SDETV_VS_RISE_BIT       4
`define SDETV_VS_WIDTH_LSB      4
`define SDETV_PIX_ADJ_LSB       6
`define SDETV_CRC_EN_BIT        4
`define SDETV_CGMS_ODD_BIT      5
`define SDETV_CGMS_EVEN_BIT     6
`define SDETV_WSS_EN_BIT        7
`define SDETV_WSS_BLANK_BIT     7
`define SDETV_SHAPING_MASK      8'h0f

// ----------------------------------------------------------------
// Timing values
// ----------------------------------------------------------------
`define SDETV_CLK_MHZ           100
`define SDETV_VS_RISE_EXTRA_US  32
`define SDETV_VS_RISE_EXTRA_CYC (`SDETV_VS_RISE_EXTRA_US * `SDETV_CLK_MHZ)
`define SDETV_SHAPING_0DB       4'h6
`define SDETV_SHAPING_MAX       4'hc
`define SDETV_HV_CYC_0          5'h00
`define SDETV_HV_CYC_1          5'h04
`define SDETV_HV_CYC_2          5'h08
`define SDETV_HV_CYC_3          5'h12
`define SDETV_WIDTH_CYC_0       8'h01
`define SDETV_WIDTH_CYC_1       8'h04
`define SDETV_WIDTH_CYC_2       8'h10
`define SDETV_WIDTH_CYC_3       8'h80

`endif

//--- sdetv_pkg.sv
`default_nettype none
package sdetv_pkg;
    // Register byte
    typedef logic [7:0] sdetv_byte_t;
    // Timing generator modes
    typedef enum logic [1:0] {
        SDETV_MODE0 = 2'h0,
        SDETV_MODE1 = 2'h1,
        SDETV_MODE2 = 2'h2,
        SDETV_MODE3 = 2'h3
    } sdetv_mode_t;
endpackage
`default_nettype wire

//--- sdetv_regs.sv
// Overview of operation
// R1 - The sync delay field gives 0, 4, 8 or 18 clocks from horizontal to vertical sync.
// R2 - In mode 1 a control bit adds 32 us to the vertical sync rising-edge delay.
// R3 - In mode 2 the vertical sync width field gives 1, 4, 16 or 128 clocks.
// R4 - Bits 7:6 shift pixel data against horizontal sync by 0 to 3 clocks.
// R5 - The 32-bit subcarrier word sits LSB first in four registers and resets to NTSC.
// R6 - The 10-bit subcarrier phase joins the phase register with bits 7:6 of the LSB register.
// R7 - Even and odd caption data each come from two byte registers, low byte first.
// R8 - Pedestal bits map to lines 10 to 25 per field and a one disables pedestal.
// R9 - The 20-bit copy payload is assembled over three registers and its low 14 bits are WSS.
// R10 - The copy control register enables CRC, odd and even copy insertion and WSS insertion.
// R11 - Y, Cb and Cr scales are 10 bits with low bits from the shared LSB register.
// R12 - The whole hue register gives the chroma hue adjustment.
// R13 - The shaping gain runs from -4 dB to +4 dB and only counts when its enable is set.
// R14 - Brightness is bits 6:0 and bit 7 blanks WSS data.
// R15 - Sync width and delay fields act only in sync master mode.
`timescale 1ns/1ns
`default_nettype none
`include "sdetv_cfg.svh"

module sdetv_regs (
    input  wire logic                 CLK,
    input  wire logic                 NRST,
    input  wire logic [7:0]           REG_ADDR,
    input  wire logic                 REG_WR,
    input  wire logic                 REG_RD,
    input  wire sdetv_pkg::sdetv_byte_t REG_WDATA,
    output var  sdetv_pkg::sdetv_byte_t REG_RDATA,
    output logic                      REG_RVALID,
    input  wire logic                 SD_MASTER,
    input  wire sdetv_pkg::sdetv_mode_t SD_TIMING_MODE,
    input  wire logic                 LUMA_SHAPING_FILTER_EN,
    output logic [7:0]                HS_WIDTH_CYC,
    output logic [4:0]                HV_DELAY_CYC,
    output logic [11:0]               VS_RISE_DELAY_CYC,
    output logic [7:0]                VS_WIDTH_CYC,
    output logic [1:0]                PIXEL_ADJUST_CYC,
    output logic [31:0]               FSC_FREQ,
    output logic [9:0]                FSC_PHASE,
    output logic [15:0]               CAPTION_EVEN,
    output logic [15:0]               CAPTION_ODD,
    output logic [15:0]               PEDESTAL_OFF_ODD,
    output logic [15:0]               PEDESTAL_OFF_EVEN,
    output logic [19:0]               CGMS_DATA,
    output logic [13:0]               WSS_DATA,
    output logic                      CGMS_CRC_EN,
    output logic                      CGMS_ODD_EN,
    output logic                      CGMS_EVEN_EN,
    output logic                      WSS_EN,
    output logic [9:0]                Y_SCALE,
    output logic [9:0]                CB_SCALE,
    output logic [9:0]                CR_SCALE,
    output logic [7:0]                HUE_ADJUST,
    output logic [6:0]                BRIGHTNESS,
    output logic                      WSS_BLANK,
    output logic [3:0]                LUMA_SHAPING_GAIN
);
    import sdetv_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Address to array index, valid when in range
    function automatic logic [4:0] idx_of(input logic [7:0] a);
        logic [7:0] d;
        d = a - `SDETV_ADDR_TIMING1;
        return d[4:0];
    endfunction

    function automatic logic in_map(input logic [7:0] a);
        return (a >= `SDETV_ADDR_TIMING1) && (a <= `SDETV_ADDR_SHAPING);
    endfunction

    // Sync width code to cycles: 1, 4, 16, 128
    function automatic logic [7:0] width_cycles(input logic [1:0] code);
        case (code)
            2'h0:    return `SDETV_WIDTH_CYC_0;
            2'h1:    return `SDETV_WIDTH_CYC_1;
            2'h2:    return `SDETV_WIDTH_CYC_2;
            default: return `SDETV_WIDTH_CYC_3;
        endcase
    endfunction

    // Reset value per register index
    function automatic sdetv_byte_t reset_of(input logic [4:0] i);
        case (i + 5'(`SDETV_ADDR_TIMING1))
            5'(`SDETV_ADDR_FSC0): return `SDETV_RST_FSC0;
            5'(`SDETV_ADDR_FSC1): return `SDETV_RST_FSC1;
            5'(`SDETV_ADDR_FSC2): return `SDETV_RST_FSC2;
            5'(`SDETV_ADDR_FSC3): return `SDETV_RST_FSC3;
            default:              return `SDETV_RST_OTHER;
        endcase
    endfunction

    sdetv_byte_t regs [`SDETV_NUM_REGS];

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    // Byte writes; NTSC subcarrier word after reset
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            for (int i = 0; i < `SDETV_NUM_REGS; i++) begin
                regs[i] <= reset_of(5'(i)); // R5
            end
        end else if (REG_WR && in_map(REG_ADDR)) begin
            if (REG_ADDR == `SDETV_ADDR_SHAPING) begin
                regs[idx_of(REG_ADDR)] <= REG_WDATA & `SDETV_SHAPING_MASK;
            end else begin
                regs[idx_of(REG_ADDR)] <= REG_WDATA;
            end
        end
    end

    // Read port, one cycle latency, unmapped reads zero
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            REG_RDATA  <= 8'h00;
            REG_RVALID <= 1'b0;
        end else begin
            REG_RVALID <= REG_RD;
            REG_RDATA  <= (REG_RD && in_map(REG_ADDR)) ? regs[idx_of(REG_ADDR)] : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Sync timing outputs
    // ----------------------------------------------------------------
    sdetv_byte_t t1;
    logic [4:0]  next_hv;
    assign t1 = regs[idx_of(`SDETV_ADDR_TIMING1)];

    // Horizontal to vertical delay decode
    always_comb begin
        case (t1[`SDETV_HV_DELAY_LSB +: 2])
            2'h0:    next_hv = `SDETV_HV_CYC_0;
            2'h1:    next_hv = `SDETV_HV_CYC_1;
            2'h2:    next_hv = `SDETV_HV_CYC_2;
            default: next_hv = `SDETV_HV_CYC_3;
        endcase
    end

    // Sync fields only drive the generator as master
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            HS_WIDTH_CYC      <= 8'h00;
            HV_DELAY_CYC      <= 5'h00;
            VS_RISE_DELAY_CYC <= 12'h000;
            VS_WIDTH_CYC      <= 8'h00;
            PIXEL_ADJUST_CYC  <= 2'h0;
        end else begin
            PIXEL_ADJUST_CYC <= t1[`SDETV_PIX_ADJ_LSB +: 2]; // R4
            if (SD_MASTER) begin // R15
                HS_WIDTH_CYC <= width_cycles(t1[`SDETV_HS_WIDTH_LSB +: 2]);
                HV_DELAY_CYC <= next_hv; // R1
                if (SD_TIMING_MODE == SDETV_MODE1 && t1[`SDETV_VS_RISE_BIT]) begin
                    VS_RISE_DELAY_CYC <= 12'(`SDETV_VS_RISE_EXTRA_CYC) + 12'(next_hv); // R2
                end else begin
                    VS_RISE_DELAY_CYC <= 12'(next_hv);
                end
                if (SD_TIMING_MODE == SDETV_MODE2) begin
                    VS_WIDTH_CYC <= width_cycles(t1[`SDETV_VS_WIDTH_LSB +: 2]); // R3
                end else begin
                    VS_WIDTH_CYC <= 8'h00;
                end
            end else begin
                HS_WIDTH_CYC      <= 8'h00;
                HV_DELAY_CYC      <= 5'h00;
                VS_RISE_DELAY_CYC <= 12'h000;
                VS_WIDTH_CYC      <= 8'h00;
            end
        end
    end

    // ----------------------------------------------------------------
    // Subcarrier, caption and pedestal outputs
    // ----------------------------------------------------------------
    sdetv_byte_t lsb;
    assign lsb = regs[idx_of(`SDETV_ADDR_SCALE_LSB)];

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            FSC_FREQ          <= 32'h0;
            FSC_PHASE         <= 10'h0;
            CAPTION_EVEN      <= 16'h0;
            CAPTION_ODD       <= 16'h0;
            PEDESTAL_OFF_ODD  <= 16'h0;
            PEDESTAL_OFF_EVEN <= 16'h0;
        end else begin
            FSC_FREQ <= {regs[idx_of(`SDETV_ADDR_FSC3)], regs[idx_of(`SDETV_ADDR_FSC2)],
                         regs[idx_of(`SDETV_ADDR_FSC1)], regs[idx_of(`SDETV_ADDR_FSC0)]}; // R5
            FSC_PHASE <= {regs[idx_of(`SDETV_ADDR_PHASE)], lsb[7:6]}; // R6
            CAPTION_EVEN <= {regs[idx_of(`SDETV_ADDR_CAP_EVEN_HI)],
                             regs[idx_of(`SDETV_ADDR_CAP_EVEN_LO)]}; // R7
            CAPTION_ODD  <= {regs[idx_of(`SDETV_ADDR_CAP_ODD_HI)],
                             regs[idx_of(`SDETV_ADDR_CAP_ODD_LO)]}; // R7
            // Bit 0 is line 10, bit 15 is line 25
            PEDESTAL_OFF_ODD  <= {regs[idx_of(`SDETV_ADDR_PED_ODD_B)],
                                  regs[idx_of(`SDETV_ADDR_PED_ODD_A)]}; // R8
            PEDESTAL_OFF_EVEN <= {regs[idx_of(`SDETV_ADDR_PED_EVEN_B)],
                                  regs[idx_of(`SDETV_ADDR_PED_EVEN_A)]}; // R8
        end
    end

    // ----------------------------------------------------------------
    // Copy protection, WSS and picture adjust outputs
    // ----------------------------------------------------------------
    sdetv_byte_t cc;
    sdetv_byte_t cm;
    sdetv_byte_t cl;
    sdetv_byte_t br;
    logic [3:0]  gain;
    assign cc   = regs[idx_of(`SDETV_ADDR_COPY_CTRL)];
    assign cm   = regs[idx_of(`SDETV_ADDR_COPY_MID)];
    assign cl   = regs[idx_of(`SDETV_ADDR_COPY_LOW)];
    assign br   = regs[idx_of(`SDETV_ADDR_BRIGHT)];
    assign gain = regs[idx_of(`SDETV_ADDR_SHAPING)][3:0];

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            CGMS_DATA         <= 20'h0;
            WSS_DATA          <= 14'h0;
            CGMS_CRC_EN       <= 1'b0;
            CGMS_ODD_EN       <= 1'b0;
            CGMS_EVEN_EN      <= 1'b0;
            WSS_EN            <= 1'b0;
            Y_SCALE           <= 10'h0;
            CB_SCALE          <= 10'h0;
            CR_SCALE          <= 10'h0;
            HUE_ADJUST        <= 8'h00;
            BRIGHTNESS        <= 7'h00;
            WSS_BLANK         <= 1'b0;
            LUMA_SHAPING_GAIN <= `SDETV_SHAPING_0DB;
        end else begin
            CGMS_DATA    <= {cc[3:0], cm[7:6], cm[5:0], cl}; // R9
            WSS_DATA     <= {cm[5:0], cl}; // R9
            CGMS_CRC_EN  <= cc[`SDETV_CRC_EN_BIT]; // R10
            CGMS_ODD_EN  <= cc[`SDETV_CGMS_ODD_BIT]; // R10
            CGMS_EVEN_EN <= cc[`SDETV_CGMS_EVEN_BIT]; // R10
            WSS_EN       <= cc[`SDETV_WSS_EN_BIT]; // R10
            Y_SCALE  <= {regs[idx_of(`SDETV_ADDR_Y_SCALE)], lsb[1:0]}; // R11
            CB_SCALE <= {regs[idx_of(`SDETV_ADDR_CB_SCALE)], lsb[3:2]}; // R11
            CR_SCALE <= {regs[idx_of(`SDETV_ADDR_CR_SCALE)], lsb[5:4]}; // R11
            HUE_ADJUST <= regs[idx_of(`SDETV_ADDR_HUE)]; // R12
            BRIGHTNESS <= br[6:0]; // R14
            WSS_BLANK  <= br[`SDETV_WSS_BLANK_BIT]; // R14
            // Disabled filter sits at 0 dB; reserved codes clamp to +4 dB
            if (!LUMA_SHAPING_FILTER_EN) begin
                LUMA_SHAPING_GAIN <= `SDETV_SHAPING_0DB; // R13
            end else if (gain > `SDETV_SHAPING_MAX) begin
                LUMA_SHAPING_GAIN <= `SDETV_SHAPING_MAX; // R13
            end else begin
                LUMA_SHAPING_GAIN <= gain; // R13
            end
        end
    end

endmodule
`default_nettype wire

//--- sdetv_regs_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module sdetv_regs_monitor (
    input wire logic                   CLK,
    input wire logic                   NRST,
    input wire logic [7:0]             REG_ADDR,
    input wire logic                   REG_WR,
    input wire logic [7:0]             REG_WDATA,
    input wire logic                   SD_MASTER,
    input wire sdetv_pkg::sdetv_mode_t SD_TIMING_MODE,
    input wire logic                   LUMA_SHAPING_FILTER_EN,
    input wire logic [4:0]             HV_DELAY_CYC,
    input wire logic [11:0]            VS_RISE_DELAY_CYC,
    input wire logic [7:0]             VS_WIDTH_CYC,
    input wire logic [1:0]             PIXEL_ADJUST_CYC,
    input wire logic [31:0]            FSC_FREQ,
    input wire logic [9:0]             FSC_PHASE,
    input wire logic [19:0]            CGMS_DATA,
    input wire logic [13:0]            WSS_DATA,
    input wire logic                   CGMS_CRC_EN,
    input wire logic                   CGMS_ODD_EN,
    input wire logic                   CGMS_EVEN_EN,
    input wire logic                   WSS_EN,
    input wire logic [3:0]             LUMA_SHAPING_GAIN
);
    import sdetv_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // Decoded timing follows codes, mode and master select
    hv_delay_a: assert property (
        HV_DELAY_CYC inside {5'h0, 5'h4, 5'h8, 5'h12}
        && ($past(SD_MASTER) || HV_DELAY_CYC == 5'h0)) else $error("sync delay wrong");
    vs_rise_a: assert property (
        VS_RISE_DELAY_CYC == 12'(HV_DELAY_CYC) || ($past(SD_TIMING_MODE) == SDETV_MODE1
        && VS_RISE_DELAY_CYC == 12'(HV_DELAY_CYC) + 12'hc80)) else $error("rise delay wrong");
    vs_width_a: assert property (
        $past(NRST) |-> (VS_WIDTH_CYC != 8'h0) == ($past(SD_MASTER)
        && $past(SD_TIMING_MODE) == SDETV_MODE2)) else $error("vsync width gating wrong");
    // Byte writes reach their fields two edges later
    pix_adjust_a: assert property (
        REG_WR && REG_ADDR == 8'h8b |=> ##1 PIXEL_ADJUST_CYC == $past(REG_WDATA[7:6], 2))
        else $error("pixel adjust wrong");
    fsc_top_a: assert property (
        REG_WR && REG_ADDR == 8'h8f |=> ##1 FSC_FREQ[31:24] == $past(REG_WDATA, 2))
        else $error("subcarrier top byte wrong");
    phase_high_a: assert property (
        REG_WR && REG_ADDR == 8'h90 |=> ##1 FSC_PHASE[9:2] == $past(REG_WDATA, 2))
        else $error("phase high bits wrong");
    copy_ctrl_a: assert property (
        REG_WR && REG_ADDR == 8'h99 |=> ##1 {WSS_EN, CGMS_EVEN_EN, CGMS_ODD_EN, CGMS_CRC_EN,
        CGMS_DATA[19:16]} == $past(REG_WDATA, 2)) else $error("copy control wrong");
    wss_share_a: assert property (
        WSS_DATA == CGMS_DATA[13:0]) else $error("wss bits differ");
    shaping_gain_a: assert property (
        LUMA_SHAPING_GAIN <= 4'hc && ($past(LUMA_SHAPING_FILTER_EN) || LUMA_SHAPING_GAIN == 4'h6))
        else $error("shaping gain wrong");
endmodule
bind sdetv_regs sdetv_regs_monitor sdetv_regs_monitor_inst (.*);
`default_nettype wire

//--- sdetv_host.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Host side of the register port
// ------------------------------
module sdetv_host (
    input  wire logic       clk,
    output logic      [7:0] addr,
    output logic            wr,
    output logic            rd,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata,
    input  wire logic       rvalid
);
    // Idle bus at time zero
    initial begin
        addr = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end
    // One byte write, then wait until the fields settle
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    // One byte read, bounded wait for the valid pulse
    task automatic get(input logic [7:0] a, output logic [7:0] d);
        int n;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rvalid !== 1'b1 && n < 4);
        d = rdata;
        if (rvalid !== 1'b1) begin
            sdetv_regs_bench.err_count++;
            sdetv_regs_bench.complete_run();
        end
    endtask
endmodule
`default_nettype wire

//--- sdetv_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// Bench top
// ------------------------------
module sdetv_regs_bench;
    import sdetv_pkg::*;
    logic             CLK = 1'b0;
    logic             NRST = 1'b0;
    logic             SD_MASTER = 1'b0;
    sdetv_mode_t      SD_TIMING_MODE = SDETV_MODE0;
    logic             LUMA_SHAPING_FILTER_EN = 1'b0;
    int               err_count = 0;
    int               total_checks = 0;
    wire logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, HS_WIDTH_CYC, VS_WIDTH_CYC, HUE_ADJUST;
    wire logic        REG_WR, REG_RD, REG_RVALID, CGMS_CRC_EN, CGMS_ODD_EN, CGMS_EVEN_EN;
    wire logic        WSS_EN, WSS_BLANK;
    wire logic [1:0]  PIXEL_ADJUST_CYC;
    wire logic [3:0]  LUMA_SHAPING_GAIN;
    wire logic [4:0]  HV_DELAY_CYC;
    wire logic [6:0]  BRIGHTNESS;
    wire logic [9:0]  FSC_PHASE, Y_SCALE, CB_SCALE, CR_SCALE;
    wire logic [11:0] VS_RISE_DELAY_CYC;
    wire logic [13:0] WSS_DATA;
    wire logic [15:0] CAPTION_EVEN, CAPTION_ODD, PEDESTAL_OFF_ODD, PEDESTAL_OFF_EVEN;
    wire logic [19:0] CGMS_DATA;
    wire logic [31:0] FSC_FREQ;
    sdetv_regs sdetv_regs_inst (.*);
    sdetv_host sdetv_host_inst (.clk(CLK), .addr(REG_ADDR), .wr(REG_WR), .rd(REG_RD),
        .wdata(REG_WDATA), .rdata(REG_RDATA), .rvalid(REG_RVALID));
    // 100 MHz clock
    always #5 CLK = ~CLK;
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reset values read back, unmapped writes ignored
    task automatic t_reset();
        logic [7:0] d;
        logic [7:0] e;
        sdetv_host_inst.put(8'ha3, 8'hff);
        sdetv_host_inst.put(8'h8a, 8'hff);
        for (int a = 8'h8b; a <= 8'ha3; a++) begin
            sdetv_host_inst.get(8'(a), d);
            e = (a >= 8'h8c && a <= 8'h8f) ? 8'(32'h21f07c1f >> (8 * (a - 8'h8c))) : 8'h00;
            chk(d, e);
        end
        chk(FSC_FREQ, 32'h21f07c1f);
        chk(LUMA_SHAPING_GAIN, 4'h6);
    endtask
    // Every timing code in modes 1 and 2, one code in mode 3, then slave
    task automatic t_timing();
        logic [4:0] hv [4] = '{5'h0, 5'h4, 5'h8, 5'h12};
        logic [7:0] wd [4] = '{8'h1, 8'h4, 8'h10, 8'h80};
        for (int i = 0; i < 4; i++) begin
            @(posedge CLK);
            SD_MASTER <= 1'b1;
            SD_TIMING_MODE <= SDETV_MODE1;
            sdetv_host_inst.put(8'h8b, 8'(i * 8'h45 + 8'h10));
            chk(HV_DELAY_CYC, hv[i]);
            chk(VS_RISE_DELAY_CYC, hv[i] + 12'hc80);
            chk({VS_WIDTH_CYC, PIXEL_ADJUST_CYC}, i);
            chk(HS_WIDTH_CYC, wd[i]);
            @(posedge CLK);
            SD_TIMING_MODE <= SDETV_MODE2;
            sdetv_host_inst.put(8'h8b, 8'(i * 8'h10));
            chk({VS_WIDTH_CYC, VS_RISE_DELAY_CYC}, {wd[i], 12'h0});
        end
        @(posedge CLK);
        SD_TIMING_MODE <= SDETV_MODE3;
        sdetv_host_inst.put(8'h8b, 8'hdf);
        chk({VS_RISE_DELAY_CYC, VS_WIDTH_CYC}, {12'h12, 8'h0});
        @(posedge CLK);
        SD_TIMING_MODE <= SDETV_MODE1;
        sdetv_host_inst.put(8'h8b, 8'h0c);
        chk(VS_RISE_DELAY_CYC, 12'h12);
        @(posedge CLK);
        SD_MASTER <= 1'b0;
        SD_TIMING_MODE <= SDETV_MODE0;
        sdetv_host_inst.put(8'h8b, 8'hff);
        chk({HV_DELAY_CYC, VS_RISE_DELAY_CYC, VS_WIDTH_CYC}, 25'h0);
        chk({HS_WIDTH_CYC, PIXEL_ADJUST_CYC}, {8'h0, 2'h3});
    endtask
    // Two complementary patterns through every data register
    task automatic t_data();
        logic [7:0] b [8'h8c:8'ha1];
        logic [7:0] d;
        for (int k = 0; k < 2; k++) begin
            for (int a = 8'h8c; a <= 8'ha1; a++) begin
                b[a] = 8'(a) ^ (k ? 8'ha5 : 8'h5a);
                sdetv_host_inst.put(8'(a), b[a]);
            end
            chk(FSC_FREQ, {b[8'h8f], b[8'h8e], b[8'h8d], b[8'h8c]});
            chk(FSC_PHASE, {b[8'h90], b[8'h9c][7:6]});
            chk({CAPTION_ODD, CAPTION_EVEN}, {b[8'h94], b[8'h93], b[8'h92], b[8'h91]});
            chk(PEDESTAL_OFF_ODD, {b[8'h96], b[8'h95]});
            chk(PEDESTAL_OFF_EVEN, {b[8'h98], b[8'h97]});
            chk(CGMS_DATA, {b[8'h99][3:0], b[8'h9a], b[8'h9b]});
            chk(WSS_DATA, {b[8'h9a][5:0], b[8'h9b]});
            chk({WSS_EN, CGMS_EVEN_EN, CGMS_ODD_EN, CGMS_CRC_EN}, b[8'h99][7:4]);
            chk({Y_SCALE, CB_SCALE}, {b[8'h9d], b[8'h9c][1:0], b[8'h9e], b[8'h9c][3:2]});
            chk(CR_SCALE, {b[8'h9f], b[8'h9c][5:4]});
            chk(HUE_ADJUST, b[8'ha0]);
            chk({WSS_BLANK, BRIGHTNESS}, b[8'ha1]);
            sdetv_host_inst.get(8'h9b, d);
            chk(d, b[8'h9b]);
        end
    endtask
    // Shaping gain codes, clamp, stored width and disable
    task automatic t_shape();
        logic [3:0] c [4] = '{4'h0, 4'h6, 4'hc, 4'hf};
        logic [7:0] d;
        @(posedge CLK);
        LUMA_SHAPING_FILTER_EN <= 1'b1;
        foreach (c[i]) begin
            sdetv_host_inst.put(8'ha2, {4'hf, c[i]});
            chk(LUMA_SHAPING_GAIN, (c[i] > 4'hc) ? 4'hc : c[i]);
        end
        sdetv_host_inst.get(8'ha2, d);
        chk(d, 8'h0f);
        @(posedge CLK);
        LUMA_SHAPING_FILTER_EN <= 1'b0;
        repeat (2) @(posedge CLK);
        chk(LUMA_SHAPING_GAIN, 4'h6);
    endtask
    // Main sequence with a second reset mid-run
    initial begin
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        t_reset();
        t_timing();
        t_data();
        t_shape();
        @(posedge CLK);
        NRST <= 1'b0;
        repeat (4) @(posedge CLK);
        NRST <= 1'b1;
        t_reset();
        complete_run();
    end
endmodule
`default_nettype wire
